// file: bench/pcif_chk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Bus and flag checks
// ----
module pcif_chk #(
    parameter int PINS = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [PINS-1:0] port_pin_input,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic change_irq,
    input wire logic irq
);
    // All checks sample on the clock; all but a_reset_quiet rest while reset is high.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // A read of core control predicts the next level of change_irq.
    wire logic rd_core = pready && !pwrite && paddr[7:0] == 8'h0c;

    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_idle_quiet: assert property (!psel |=> !pready)
        else $error("pready without setup");
    a_err_unmapped: assert property (pready && paddr[7:0] > 8'h14 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr[7:0] < 8'h18 && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access refused");
    a_flag_upper: assert property (pready && !pwrite && paddr[7:0] == 8'h00
        |-> prdata[31:6] == 26'h0) else $error("flag upper bits set");
    a_master_off: assert property (rd_core && !prdata[3] |=> !change_irq)
        else $error("change_irq with master off");
    a_summary_irq: assert property (rd_core && prdata[3] && prdata[0] |=> change_irq)
        else $error("change_irq missing");
    a_reset_quiet: assert property (disable iff (1'h0) reset |=>
        !pready && !change_irq && !irq) else $error("outputs live after reset");
endmodule : pcif_chk
bind pcif_top pcif_chk #(.PINS(PINS)) u_chk (.sys_clk(sys_clk), .reset(reset),
    .port_pin_input(port_pin_input), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .change_irq(change_irq), .irq(irq));
`default_nettype wire

// file: bench/pcif_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Port pins outside the block
// ----
module pcif_pin_model (
    input wire logic sys_clk,
    output logic [5:0] pins
);
    initial pins = 6'h00;
    // Sets every pin level just after the next edge.
    task automatic drive(input logic [5:0] v);
        @(posedge sys_clk);
        pins <= v;
    endtask : drive
    // Flips the masked pins for one cycle, lead edges from now.
    task automatic pulse(input int lead, input logic [5:0] m);
        repeat (lead) @(posedge sys_clk);
        pins <= pins ^ m;
        @(posedge sys_clk);
        pins <= pins ^ m;
    endtask : pulse
endmodule : pcif_pin_model
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// Register bus bench
// ----
module tb_top;
    logic sys_clk, reset, psel, penable, pwrite, pslverr, pready, change_irq, irq, e;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [5:0] pins;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    pcif_pin_model pm (.sys_clk(sys_clk), .pins(pins));
    pcif_top #(.PINS(6)) dut (.sys_clk(sys_clk), .reset(reset), .port_pin_input(pins),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .change_irq(change_irq),
        .irq(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One transfer; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        // Ready is looked at mid-cycle, where it is settled; the transfer ends at the next edge.
        @(negedge sys_clk);
        while (pready !== 1'h1) @(negedge sys_clk);
        q = prdata;
        e = pslverr;
        @(posedge sys_clk);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'h0, a, 32'h0);
        check(q, exp);
        check(32'(e), 32'(err));
    endtask : rd

    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // A hang counts as a mismatch and ends the run.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // Main sequence of register and pin scenarios.
    initial begin
        reset = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'h0;
        for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0, 1'h0);
        apb(1'h1, 8'h00, 32'hffffffff);
        rd(8'h00, 32'h3f, 1'h0);
        apb(1'h1, 8'h00, 32'h0);
        rd(8'h00, 32'h0, 1'h0);
        apb(1'h1, 8'h08, 32'h05);
        apb(1'h1, 8'h04, 32'h06);
        pm.drive(6'h3f);
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 32'h05, 1'h0);
        rd(8'h0c, 32'h01, 1'h0);
        check(32'(change_irq), 32'h0);
        apb(1'h1, 8'h00, 32'h0);
        pm.drive(6'h00);
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 32'h06, 1'h0);
        apb(1'h1, 8'h0c, 32'h08);
        repeat (3) @(posedge sys_clk);
        check(32'(change_irq), 32'h1);
        rd(8'h0c, 32'h09, 1'h0);
        check(32'(irq), 32'h0);
        apb(1'h1, 8'h14, 32'h3);
        repeat (3) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        apb(1'h1, 8'h00, 32'h0);
        apb(1'h1, 8'h10, 32'h1);
        repeat (3) @(posedge sys_clk);
        check(32'(change_irq), 32'h0);
        check(32'(irq), 32'h0);
        rd(8'h40, 32'h0, 1'h1);
        repeat (3) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        rd(8'h10, 32'h2, 1'h0);
        apb(1'h1, 8'h10, 32'h2);
        apb(1'h1, 8'h08, 32'h0d);
        apb(1'h1, 8'h04, 32'h0e);
        // Pin 3 rise edge lands on the flag one cycle before the clearing write completes; its fall edge lands as the write completes.
        fork
            pm.pulse(2, 6'h08);
            begin
                repeat (3) @(posedge sys_clk);
                apb(1'h1, 8'h00, 32'h0);
            end
        join
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 32'h08, 1'h0);
        check(32'(irq), 32'h1);
        reset <= 1'h1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'h0;
        rd(8'h00, 32'h0, 1'h0);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// file: rtl/pcif_defs.svh
`ifndef PCIF_DEFS_SVH
`define PCIF_DEFS_SVH

// Register byte offsets on the APB bus.
`define PCIF_OFS_FLAGS 8'h00
`define PCIF_OFS_FALL_EN 8'h04
`define PCIF_OFS_RISE_EN 8'h08
`define PCIF_OFS_CORE_CTRL 8'h0c
`define PCIF_OFS_IRQ_STATUS 8'h10
`define PCIF_OFS_IRQ_MASK 8'h14
`define PCIF_ADDR_W 8

// Field positions in the core interrupt control register.
`define PCIF_CTRL_SUMMARY_BIT 0
`define PCIF_CTRL_MASTER_EN_BIT 3

// Reset values.
`define PCIF_PINS_RST 6'h00
`define PCIF_BYTE_RST 8'h00
`define PCIF_IRQ_RST 2'h0

// Event bit positions in the interrupt status register.
`define PCIF_EVT_CHANGE 0
`define PCIF_EVT_ERROR 1

`endif

// file: rtl/pcif_edge_detect.sv
`timescale 1ns/100ps
`default_nettype none

`include "pcif_defs.svh"

module pcif_edge_detect #(
    parameter int PINS = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] rise_pulse,
    output logic [PINS-1:0] fall_pulse
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        logic [PINS-1:0] sync1;
        logic [PINS-1:0] sync2;
        logic [PINS-1:0] prev;
        logic [2:0] primed;
    } pcif_sync_type;

    pcif_sync_type state_ff;
    pcif_sync_type nxt_state;

    // Two-stage synchroniser, then a history stage for comparison.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.sync1 = pin_in;
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.prev = state_ff.sync2;
        nxt_state.primed = {state_ff.primed[1:0], 1'b1}; // History is valid after three edges.
    end

    // Registers the state copy.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Edges are compared only once the history is valid after reset.
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            assign rise_pulse[g] = state_ff.primed[2] & state_ff.sync2[g] & ~state_ff.prev[g];
            assign fall_pulse[g] = state_ff.primed[2] & ~state_ff.sync2[g] & state_ff.prev[g];
        end
    endgenerate

endmodule : pcif_edge_detect

`default_nettype wire

// file: rtl/pcif_pkg.sv
package pcif_pkg;

    // Pin vector carried between the edge detector and the register file.
    typedef logic [5:0] pcif_pins_type;

    // Edge detector result.
    typedef struct packed {
        pcif_pins_type rise;
        pcif_pins_type fall;
    } pcif_edges_type;

    // APB slave phase.
    typedef enum logic [1:0] {
        PCIF_IDLE = 2'b00,
        PCIF_ACCESS = 2'b01
    } pcif_phase_type;

endpackage : pcif_pkg

// file: rtl/pcif_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "pcif_defs.svh"

module pcif_top #(
    parameter int PINS = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [PINS-1:0] port_pin_input,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic change_irq,
    output logic irq
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        pcif_pkg::pcif_pins_type flags;
        pcif_pkg::pcif_pins_type rise_en;
        pcif_pkg::pcif_pins_type fall_en;
        logic master_en;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        pcif_pkg::pcif_phase_type phase;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic change_irq;
        logic irq;
    } pcif_state_type;

    pcif_state_type state_ff;
    pcif_state_type nxt_state;

    pcif_pkg::pcif_edges_type edges;
    logic [`PCIF_ADDR_W-1:0] addr;
    logic wr_strobe;
    logic setup;
    logic [5:0] wr_pins;
    logic [1:0] evt;
    logic any_flag;

    // -------------------------------------------------------------------
    // Edge detection
    // -------------------------------------------------------------------
    pcif_edge_detect #(
        .PINS(PINS)
    ) u_edge (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(port_pin_input),
        .rise_pulse(edges.rise),
        .fall_pulse(edges.fall)
    );

    // Decodes whether an address is one of the mapped registers.
    function automatic logic pcif_mapped(input logic [`PCIF_ADDR_W-1:0] a);
        pcif_mapped = (a == `PCIF_OFS_FLAGS) || (a == `PCIF_OFS_FALL_EN) ||
            (a == `PCIF_OFS_RISE_EN) || (a == `PCIF_OFS_CORE_CTRL) ||
            (a == `PCIF_OFS_IRQ_STATUS) || (a == `PCIF_OFS_IRQ_MASK);
    endfunction : pcif_mapped

    // Bus decode of the current request.
    assign addr = paddr[`PCIF_ADDR_W-1:0];
    assign setup = psel & ~penable;
    assign wr_strobe = psel & penable & pwrite & state_ff.ready;
    assign wr_pins = pwdata[5:0];

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        evt = `PCIF_IRQ_RST;
        any_flag = 1'b0;

        // APB handshake: no wait state, ready for exactly one cycle.
        nxt_state.ready = 1'b0;
        nxt_state.slverr = 1'b0;
        unique case (state_ff.phase)
            pcif_pkg::PCIF_IDLE: begin
                if (setup) begin
                    nxt_state.phase = pcif_pkg::PCIF_ACCESS;
                    nxt_state.ready = 1'b1;
                    nxt_state.slverr = ~pcif_mapped(addr);
                    nxt_state.rdata = '0;
                    if (!pwrite) begin
                        unique case (addr)
                            `PCIF_OFS_FLAGS: nxt_state.rdata[5:0] = state_ff.flags;
                            `PCIF_OFS_FALL_EN: nxt_state.rdata[5:0] = state_ff.fall_en;
                            `PCIF_OFS_RISE_EN: nxt_state.rdata[5:0] = state_ff.rise_en;
                            `PCIF_OFS_CORE_CTRL: begin
                                nxt_state.rdata[`PCIF_CTRL_MASTER_EN_BIT] = state_ff.master_en;
                                nxt_state.rdata[`PCIF_CTRL_SUMMARY_BIT] = |state_ff.flags;
                            end
                            `PCIF_OFS_IRQ_STATUS: nxt_state.rdata[1:0] = state_ff.irq_status;
                            `PCIF_OFS_IRQ_MASK: nxt_state.rdata[1:0] = state_ff.irq_mask;
                            default: nxt_state.rdata = '0;
                        endcase
                    end
                end
            end
            pcif_pkg::PCIF_ACCESS: begin
                nxt_state.phase = pcif_pkg::PCIF_IDLE;
            end
            default: nxt_state.phase = pcif_pkg::PCIF_IDLE;
        endcase

        // Register writes taken at the completing edge.
        if (wr_strobe) begin
            unique case (addr)
                `PCIF_OFS_FLAGS: nxt_state.flags = wr_pins;
                `PCIF_OFS_FALL_EN: nxt_state.fall_en = wr_pins;
                `PCIF_OFS_RISE_EN: nxt_state.rise_en = wr_pins;
                `PCIF_OFS_CORE_CTRL: nxt_state.master_en = pwdata[`PCIF_CTRL_MASTER_EN_BIT];
                `PCIF_OFS_IRQ_MASK: nxt_state.irq_mask = pwdata[1:0];
                `PCIF_OFS_IRQ_STATUS: nxt_state.irq_status = state_ff.irq_status & ~pwdata[1:0];
                default: nxt_state.flags = state_ff.flags;
            endcase
        end

        // Hardware set wins over any write, whatever master enable holds.
        nxt_state.flags = nxt_state.flags
            | (edges.rise & state_ff.rise_en)
            | (edges.fall & state_ff.fall_en);

        // Sticky events: new flag set, and access to an unmapped address.
        evt[`PCIF_EVT_CHANGE] = |((edges.rise & state_ff.rise_en) | (edges.fall & state_ff.fall_en));
        evt[`PCIF_EVT_ERROR] = setup & ~pcif_mapped(addr);
        nxt_state.irq_status = nxt_state.irq_status | evt;

        // Request outputs, registered; the master enable gates only the request.
        any_flag = |nxt_state.flags;
        nxt_state.change_irq = any_flag & nxt_state.master_en;
        nxt_state.irq = |(nxt_state.irq_status & nxt_state.irq_mask);
    end

    // -------------------------------------------------------------------
    // State register
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= '0;
            state_ff.flags <= `PCIF_PINS_RST;
            state_ff.phase <= pcif_pkg::PCIF_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata = state_ff.rdata;
    assign pready = state_ff.ready;
    assign pslverr = state_ff.slverr;
    assign change_irq = state_ff.change_irq;
    assign irq = state_ff.irq;

endmodule : pcif_top

`default_nettype wire
